// File: core/fbw_pkg.sv
package fbw_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_KEY    = 8'h04;
   localparam logic [7:0] OFF_XADDR  = 8'h08;
   localparam logic [7:0] OFF_XDATA  = 8'h0C;
   localparam logic [7:0] OFF_CADDR  = 8'h10;
   localparam logic [7:0] OFF_CDATA  = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   // control and status fields
   localparam int         CTRL_WEN_BIT   = 0;
   localparam int         CTRL_EEN_BIT   = 1;
   localparam int         ST_BUSY_BIT    = 0;
   localparam int         ST_OPEN_BIT    = 1;
   localparam int         ST_KEY1_BIT    = 2;
   localparam int         ST_ERR_BIT     = 3;
   localparam int         ST_LARGE_BIT   = 4;
   localparam logic [1:0] CTRL_RESET     = 2'h0;
   // unlock keys
   localparam logic [7:0] KEY_FIRST  = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'hF1;
   // flash geometry
   localparam int          FLASH_AW          = 14;
   localparam int          PAGE_IDX_W        = 9;
   localparam int          FLASH_BYTES_LARGE = 16384;
   localparam int          FLASH_BYTES_SMALL = 8192;
   localparam logic [13:0] RESERVED_BASE     = 14'h3E00;
   localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
   localparam int          XADDR_W           = 16;
   // timing: typical cycle times at the system clock period
   localparam int CLK_PERIOD_NS = 8;
   localparam int ERASE_TIME_NS = 15000000;
   localparam int PROG_TIME_NS  = 55000;
   localparam int ERASE_CYCLES_DEF = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_CYCLES_DEF  = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int CNT_W            = 22;
   // sequencer and key states
   typedef enum logic [3:0] {
      SQ_IDLE  = 4'b0001,
      SQ_ERASE = 4'b0010,
      SQ_PROG  = 4'b0100,
      SQ_DONE  = 4'b1000
   } fbw_seq_type;
   typedef enum logic [2:0] {
      LK_LOCKED = 3'b001,
      LK_KEY1   = 3'b010,
      LK_OPEN   = 3'b100
   } fbw_lock_type;
endpackage

// File: core/fbw_mem_if.sv
`timescale 1ns/10ps
interface fbw_mem_if;
   import fbw_pkg::*;
   logic                we;
   logic [FLASH_AW-1:0] waddr;
   logic [7:0]          wdata;
   logic [FLASH_AW-1:0] raddr;
   logic [7:0]          rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: core/fbw_flash_mem.sv
`timescale 1ns/10ps
module fbw_flash_mem
   import fbw_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // array port
   fbw_mem_if.mem    mp
);
   logic [7:0] arr_q [FLASH_BYTES_LARGE];
   logic [7:0] rdata_q;

   // byte array write
   always_ff @(posedge clk_i) begin
      if (mp.we) begin
         arr_q[mp.waddr] <= mp.wdata;
      end
   end

   // registered read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= arr_q[mp.raddr];
      end
   end

   assign mp.rdata = rdata_q;
endmodule // fbw_flash_mem

// File: core/fbw_sequencer.sv
`timescale 1ns/10ps
module fbw_sequencer
   import fbw_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int ERASE_CYCLES  = ERASE_CYCLES_DEF,
   parameter int PROG_CYCLES   = PROG_CYCLES_DEF
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // external data ram
   output logic [15:0]      external_data_ram_addr_o,
   output logic [7:0]       external_data_ram_wdata_o,
   output logic             external_data_ram_we_o,
   input  wire logic [7:0]  external_data_ram_rdata_i,
   // core status
   output logic             core_stall_o,
   output logic             flash_unlocked_o
);
   fbw_seq_type         seq_q;
   fbw_lock_type        lock_q;
   logic [1:0]          ctrl_q;
   logic [7:0]          xaddr_b_q [2];
   logic [7:0]          caddr_b_q [2];
   logic [XADDR_W-1:0]  xaddr;
   logic [XADDR_W-1:0]  caddr;
   logic                key_err_q;
   logic                ack_q;
   logic [31:0]         dat_q;
   logic [CNT_W-1:0]    cnt_q;
   logic [PAGE_IDX_W:0] idx_q;
   logic [FLASH_AW-1:0] page_q;
   logic [7:0]          xwdata_q;
   logic                xwe_q;
   logic                req;
   logic                take;
   logic                take_wr;
   logic                flash_req;
   logic                flash_ok;
   logic                launch;
   logic                refuse;
   logic                key_wr;
   logic                erase_sel;

   fbw_mem_if mem_bus ();

   fbw_flash_mem u_mem (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .mp    (mem_bus.mem)
   );

   // address hit decode
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction

   // flash address legality
   function automatic logic addr_legal(input logic [XADDR_W-1:0] a);
      logic ok;
      ok = 1'b1;
      if (LARGE_VARIANT) begin
         if (a >= XADDR_W'(FLASH_BYTES_LARGE)) begin
            ok = 1'b0;
         end
         if (a[FLASH_AW-1:PAGE_IDX_W] == RESERVED_BASE[FLASH_AW-1:PAGE_IDX_W]) begin
            ok = 1'b0;
         end
      end else if (a >= XADDR_W'(FLASH_BYTES_SMALL)) begin
         ok = 1'b0;
      end
      addr_legal = ok;
   endfunction

   assign xaddr = {xaddr_b_q[1], xaddr_b_q[0]};
   assign caddr = {caddr_b_q[1], caddr_b_q[0]};

   // request decode
   assign req       = cyc_i & stb_i & ~ack_q;
   assign flash_req = req & we_i & sel_i[0] & reg_hit(adr_i, OFF_XDATA) & ctrl_q[CTRL_WEN_BIT];
   assign flash_ok  = (lock_q == LK_OPEN) & addr_legal(xaddr);
   assign launch    = (seq_q == SQ_IDLE) & flash_req & flash_ok;
   assign refuse    = (seq_q == SQ_IDLE) & flash_req & ~flash_ok;
   assign take      = req & (seq_q == SQ_IDLE) & ~launch;
   assign take_wr   = take & we_i;
   assign key_wr    = take_wr & sel_i[0] & reg_hit(adr_i, OFF_KEY);
   assign erase_sel = ctrl_q[CTRL_EEN_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take | (seq_q == SQ_DONE);
      end
   end

   // program_store_control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (take_wr & sel_i[0] & reg_hit(adr_i, OFF_CTRL)) begin
         ctrl_q <= dat_i[1:0];
      end
   end

   // address registers, one byte lane each
   for (genvar g = 0; g < 2; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            xaddr_b_q[g] <= 8'h00;
         end else if (take_wr & sel_i[g] & reg_hit(adr_i, OFF_XADDR)) begin
            xaddr_b_q[g] <= dat_i[g*8 +: 8];
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            caddr_b_q[g] <= 8'h00;
         end else if (take_wr & sel_i[g] & reg_hit(adr_i, OFF_CADDR)) begin
            caddr_b_q[g] <= dat_i[g*8 +: 8];
         end
      end
   end

   // unlock key sequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= LK_LOCKED;
      end else if (launch | refuse) begin
         lock_q <= LK_LOCKED;
      end else if (key_wr) begin
         case (lock_q)
            LK_LOCKED: begin
               lock_q <= (dat_i[7:0] == KEY_FIRST) ? LK_KEY1 : LK_LOCKED;
            end
            LK_KEY1: begin
               lock_q <= (dat_i[7:0] == KEY_SECOND) ? LK_OPEN : LK_LOCKED;
            end
            LK_OPEN: begin
               lock_q <= LK_LOCKED;
            end
            default: begin
               lock_q <= LK_LOCKED;
            end
         endcase
      end
   end

   // sticky key error, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_err_q <= 1'b0;
      end else if (refuse
                   | (key_wr & (lock_q == LK_LOCKED) & (dat_i[7:0] != KEY_FIRST))
                   | (key_wr & (lock_q == LK_KEY1) & (dat_i[7:0] != KEY_SECOND))
                   | (key_wr & (lock_q == LK_OPEN))) begin
         key_err_q <= 1'b1;
      end else if (take_wr & sel_i[0] & reg_hit(adr_i, OFF_STATUS) & dat_i[ST_ERR_BIT]) begin
         key_err_q <= 1'b0;
      end
   end

   // erase and program sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_q  <= SQ_IDLE;
         cnt_q  <= '0;
         idx_q  <= '0;
         page_q <= '0;
      end else begin
         case (seq_q)
            SQ_IDLE: begin
               if (launch & erase_sel) begin
                  seq_q  <= SQ_ERASE;
                  cnt_q  <= CNT_W'(ERASE_CYCLES - 1);
                  idx_q  <= '0;
                  page_q <= {xaddr[FLASH_AW-1:PAGE_IDX_W], PAGE_IDX_W'(0)};
               end else if (launch) begin
                  seq_q <= SQ_PROG;
                  cnt_q <= CNT_W'(PROG_CYCLES - 1);
               end
            end
            SQ_ERASE: begin
               if (~idx_q[PAGE_IDX_W]) begin
                  idx_q <= idx_q + 1'b1;
               end
               if (cnt_q == '0) begin
                  seq_q <= SQ_DONE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            SQ_PROG: begin
               if (cnt_q == '0) begin
                  seq_q <= SQ_DONE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            SQ_DONE: begin
               seq_q <= SQ_IDLE;
            end
            default: begin
               seq_q <= SQ_IDLE;
            end
         endcase
      end
   end

   // flash array port
   always_comb begin
      mem_bus.we    = 1'b0;
      mem_bus.waddr = xaddr[FLASH_AW-1:0];
      mem_bus.wdata = dat_i[7:0];
      if (seq_q == SQ_ERASE) begin
         mem_bus.we    = ~idx_q[PAGE_IDX_W];
         mem_bus.waddr = page_q | FLASH_AW'(idx_q[PAGE_IDX_W-1:0]);
         mem_bus.wdata = ERASED_BYTE;
      end else if (launch & ~erase_sel) begin
         mem_bus.we = 1'b1;
      end
   end

   assign mem_bus.raddr = caddr[FLASH_AW-1:0];

   // external data ram write, blocked while write enable is set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xwe_q    <= 1'b0;
         xwdata_q <= 8'h00;
      end else begin
         xwe_q <= take_wr & sel_i[0] & reg_hit(adr_i, OFF_XDATA) & ~ctrl_q[CTRL_WEN_BIT];
         if (take_wr & sel_i[0] & reg_hit(adr_i, OFF_XDATA)) begin
            xwdata_q <= dat_i[7:0];
         end
      end
   end

   // read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (take & ~we_i) begin
         dat_q <= 32'h0000_0000;
         if (reg_hit(adr_i, OFF_CTRL)) begin
            dat_q[1:0] <= ctrl_q;
         end else if (reg_hit(adr_i, OFF_KEY)) begin
            dat_q <= 32'h0000_0000;
         end else if (reg_hit(adr_i, OFF_XADDR)) begin
            dat_q[XADDR_W-1:0] <= xaddr;
         end else if (reg_hit(adr_i, OFF_XDATA)) begin
            dat_q[7:0] <= external_data_ram_rdata_i;
         end else if (reg_hit(adr_i, OFF_CADDR)) begin
            dat_q[XADDR_W-1:0] <= caddr;
         end else if (reg_hit(adr_i, OFF_CDATA)) begin
            dat_q[7:0] <= mem_bus.rdata;
         end else if (reg_hit(adr_i, OFF_STATUS)) begin
            dat_q[ST_BUSY_BIT]  <= (seq_q != SQ_IDLE);
            dat_q[ST_OPEN_BIT]  <= (lock_q == LK_OPEN);
            dat_q[ST_KEY1_BIT]  <= (lock_q == LK_KEY1);
            dat_q[ST_ERR_BIT]   <= key_err_q;
            dat_q[ST_LARGE_BIT] <= LARGE_VARIANT;
         end
      end
   end

   // outputs
   assign ack_o            = ack_q;
   assign dat_o            = dat_q;
   assign external_data_ram_addr_o      = xaddr;
   assign external_data_ram_wdata_o     = xwdata_q;
   assign external_data_ram_we_o        = xwe_q;
   assign core_stall_o     = (seq_q == SQ_ERASE) | (seq_q == SQ_PROG);
   assign flash_unlocked_o = (lock_q == LK_OPEN);
endmodule // fbw_sequencer

// File: test/fbw_external_data_ram_model.sv
`timescale 1ns/10ps
module fbw_external_data_ram_model (
   // clock
   input  wire logic        clk_i,
   // ram port
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        we_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];
   assign rdata_o = mem[addr_i];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule // fbw_external_data_ram_model

// File: test/fbw_sequencer_assertions.sv
`timescale 1ns/10ps
module fbw_sequencer_assertions
   import fbw_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
   parameter int PROG_CYCLES  = PROG_CYCLES_DEF
)
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // bus
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_i,
   input wire logic        we_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // ram and status
   input wire logic [7:0]  external_data_ram_wdata_o,
   input wire logic        external_data_ram_we_o,
   input wire logic [7:0]  external_data_ram_rdata_i,
   input wire logic        core_stall_o,
   input wire logic        flash_unlocked_o
);
   logic [21:0] stall_cnt_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // busy cycle count
   always_ff @(posedge clk_i) begin
      if (rst_i || !core_stall_o) begin
         stall_cnt_q <= 22'h0;
      end else begin
         stall_cnt_q <= stall_cnt_q + 22'h1;
      end
   end
   chk_unlock_key: assert property (
      $rose(flash_unlocked_o) |-> ack_o && we_i && adr_i == OFF_KEY && dat_i[7:0] == KEY_SECOND)
      else $error("unlock without second key");
   chk_unlock_used: assert property ($fell(core_stall_o) |-> !flash_unlocked_o)
      else $error("unlock kept after flash cycle");
   chk_ram_write: assert property (
      external_data_ram_we_o |-> ack_o && we_i && adr_i == OFF_XDATA && external_data_ram_wdata_o == dat_i[7:0])
      else $error("ram write without data write");
   chk_ram_read: assert property (
      ack_o && !we_i && adr_i == OFF_XDATA |-> dat_o == {24'h0, $past(external_data_ram_rdata_i)})
      else $error("data read not from ram");
   chk_stall_len: assert property (
      $fell(core_stall_o) |-> stall_cnt_q == PROG_CYCLES || stall_cnt_q == ERASE_CYCLES)
      else $error("flash cycle length wrong");
   chk_no_ack_busy: assert property (core_stall_o |-> !ack_o)
      else $error("ack while core stalled");
   chk_resume_ack: assert property ($fell(core_stall_o) |=> ack_o)
      else $error("no ack after flash cycle");
   chk_launch_src: assert property (
      $rose(core_stall_o) |-> $past(cyc_i && stb_i && we_i && adr_i == OFF_XDATA))
      else $error("stall without data write");
   chk_launch_lock: assert property ($rose(core_stall_o) |-> $past(flash_unlocked_o))
      else $error("flash cycle while locked");
endmodule // fbw_sequencer_assertions
bind fbw_sequencer fbw_sequencer_assertions #(
   .ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES (PROG_CYCLES)
) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
   .external_data_ram_wdata_o(external_data_ram_wdata_o), .external_data_ram_we_o(external_data_ram_we_o), .external_data_ram_rdata_i(external_data_ram_rdata_i),
   .core_stall_o(core_stall_o), .flash_unlocked_o(flash_unlocked_o)
);

// File: test/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   import fbw_pkg::*;
   localparam int EC = 600;
   localparam int PC = 4;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
   logic        external_data_ram_we_o, core_stall_o, flash_unlocked_o;
   logic [7:0]  adr_i, external_data_ram_wdata_o, external_data_ram_rdata_i;
   logic [3:0]  sel_i;
   logic [15:0] external_data_ram_addr_o;
   logic [31:0] dat_i, dat_o;
   int          bad_count, tests_run, cyc_cnt;
   fbw_sequencer #(.LARGE_VARIANT(1'b1), .ERASE_CYCLES(EC), .PROG_CYCLES(PC)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
      .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .external_data_ram_addr_o(external_data_ram_addr_o), .external_data_ram_wdata_o(external_data_ram_wdata_o), .external_data_ram_we_o(external_data_ram_we_o),
      .external_data_ram_rdata_i(external_data_ram_rdata_i), .core_stall_o(core_stall_o),
      .flash_unlocked_o(flash_unlocked_o));
   fbw_external_data_ram_model ram (.clk_i(clk_i), .addr_i(external_data_ram_addr_o), .wdata_i(external_data_ram_wdata_o),
      .we_i(external_data_ram_we_o), .rdata_o(external_data_ram_rdata_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         bad_count++;
         wrap_up();
      end
   end
   // one wishbone cycle, n counts edges until ack
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output int n);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      adr_i <= a;
      we_i  <= w;
      dat_i <= d;
      sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      int n;
      wb(a, 1'b1, d, q, n);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      int n;
      wb(a, 1'b0, 32'h0, q, n);
      `CHK(q, e)
   endtask
   task automatic wt(input logic [7:0] a, input logic [31:0] d, input int e);
      logic [31:0] q;
      int n;
      wb(a, 1'b1, d, q, n);
      `CHK(n, e)
   endtask
   task automatic keys;
      wr(OFF_KEY, {24'h0, KEY_FIRST});
      wr(OFF_KEY, {24'h0, KEY_SECOND});
   endtask
   task automatic t_reset;
      rd(OFF_STATUS, 32'h10);
      rd(OFF_CTRL, 32'h0);
      wr(8'h1C, 32'hFF);
      rd(8'h1C, 32'h0);
   endtask
   task automatic t_ram;
      wr(OFF_XADDR, 32'h200);
      wt(OFF_XDATA, 32'h5A, 2);
      `CHK(ram.mem[16'h200], 8'h5A)
      rd(OFF_XDATA, 32'h5A);
   endtask
   task automatic t_flash;
      wr(OFF_CTRL, 32'h3);
      keys();
      wt(OFF_XDATA, 32'h0, EC + 3);
      wr(OFF_CADDR, 32'h200);
      rd(OFF_CDATA, 32'hFF);
      wr(OFF_CTRL, 32'h1);
      keys();
      `CHK(flash_unlocked_o, 1'b1)
      wt(OFF_XDATA, 32'h3C, PC + 3);
      `CHK(flash_unlocked_o, 1'b0)
      rd(OFF_CDATA, 32'h3C);
      rd(OFF_XDATA, 32'h5A);
      `CHK(ram.mem[16'h200], 8'h5A)
      wt(OFF_XDATA, 32'h11, 2);
      rd(OFF_CDATA, 32'h3C);
      wr(OFF_CADDR, 32'h201);
      rd(OFF_CDATA, 32'hFF);
      rd(OFF_STATUS, 32'h18);
      wr(OFF_STATUS, 32'h8);
      wr(OFF_CTRL, 32'h0);
   endtask
   task automatic t_keys;
      wr(OFF_KEY, {24'h0, KEY_FIRST});
      rd(OFF_STATUS, 32'h14);
      wr(OFF_KEY, 32'h0);
      rd(OFF_STATUS, 32'h18);
      wr(OFF_STATUS, 32'h8);
      wr(OFF_KEY, {24'h0, KEY_SECOND});
      rd(OFF_STATUS, 32'h18);
      wr(OFF_STATUS, 32'h8);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_KEY, {24'h0, KEY_FIRST});
      wr(OFF_XADDR, {18'h0, RESERVED_BASE});
      wr(OFF_KEY, {24'h0, KEY_SECOND});
      `CHK(flash_unlocked_o, 1'b1)
      wt(OFF_XDATA, 32'h12, 2);
      rd(OFF_STATUS, 32'h18);
      wr(OFF_STATUS, 32'h8);
      rd(OFF_STATUS, 32'h10);
      wr(OFF_CTRL, 32'h2);
      wt(OFF_XDATA, 32'h66, 2);
      `CHK(ram.mem[16'h3E00], 8'h66)
   endtask
   task automatic t_mid_reset;
      keys();
      `CHK(flash_unlocked_o, 1'b1)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK(flash_unlocked_o, 1'b0)
      rd(OFF_STATUS, 32'h10);
      rd(OFF_CTRL, 32'h0);
   endtask
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i  = 1'b0;
      adr_i = 8'h0;
      dat_i = 32'h0;
      sel_i = 4'hF;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_ram();
      t_flash();
      t_keys();
      t_mid_reset();
      wrap_up();
   end
endmodule // testbench
